// ===== dss_pkg.sv
package dss_pkg;
	// Host I/O addresses (memory offsets are identical)
	localparam logic [15:0] ADDR_STAT1_MONO = 16'h03BA;
	localparam logic [15:0] ADDR_STAT1_COLR = 16'h03DA;
	localparam logic [15:0] ADDR_MISC_WR = 16'h03C2;
	localparam logic [15:0] ADDR_STAT0 = 16'h03C2;
	localparam logic [15:0] ADDR_SEQ_INDEX = 16'h03C4;
	localparam logic [15:0] ADDR_SEQ_DATA = 16'h03C5;
	localparam logic [15:0] ADDR_FEAT_RD = 16'h03CA;
	localparam logic [15:0] ADDR_MISC_RD = 16'h03CC;
	// Sequencer indices
	localparam logic [2:0] SEQ_IDX_SCRATCH = 3'h0;
	localparam logic [2:0] SEQ_IDX_CLKMODE = 3'h1;
	// Field positions
	localparam int ST0_IRQ_BIT = 7;
	localparam int ST0_SENSE_BIT = 4;
	localparam int ST1_VFB_LO = 4;
	localparam int ST1_VRT_BIT = 3;
	localparam int ST1_RETRACE_BIT = 0;
	localparam int FC_VSYNC_OR_BIT = 3;
	localparam int MISC_VPOL_BIT = 7;
	localparam int MISC_HPOL_BIT = 6;
	localparam int MISC_PAGE_BIT = 5;
	localparam int MISC_CLK_LO = 2;
	localparam int MISC_MEMEN_BIT = 1;
	localparam int MISC_IOSEL_BIT = 0;
	localparam int CM_OFF_BIT = 5;
	localparam int CM_SH4_BIT = 4;
	localparam int CM_DIV_BIT = 3;
	localparam int CM_SH2_BIT = 2;
	localparam int CM_DOT8_BIT = 0;
	localparam int VRE_IRQ_LO = 4;
	localparam int CPE_SEL_LO = 4;
	// Writable masks and resets
	localparam logic [7:0] MASK_FEAT = 8'h08;
	localparam logic [7:0] MASK_MISC = 8'hEF;
	localparam logic [7:0] MASK_SCRATCH = 8'h03;
	localparam logic [7:0] MASK_CLKMODE = 8'h3D;
	localparam logic [2:0] MASK_INDEX = 3'h7;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Character clock lengths in dot clocks, minus one
	localparam logic [3:0] CHAR_LEN_9 = 4'h8;
	localparam logic [3:0] CHAR_LEN_8 = 4'h7;
	// Shift-load periods in character clocks, minus one
	localparam logic [1:0] LOAD_EVERY_1 = 2'h0;
	localparam logic [1:0] LOAD_EVERY_2 = 2'h1;
	localparam logic [1:0] LOAD_EVERY_4 = 2'h3;
	// Dot clock source codes
	typedef enum logic [1:0] {
		DSS_CLK_LOW = 2'h0,
		DSS_CLK_MID = 2'h1,
		DSS_CLK_PROG = 2'h2
	} dss_clk_sel_t;
endpackage : dss_pkg

// ===== dss_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Input status zero bit 7 shows a pending vertical-retrace interrupt when enabled.
// - Input status zero bit 4 returns live sense comparator output.
// - Misc output bit 0 is stored but does not pick the 3Bx or 3Dx base for status/feature.
// - Both address ranges are claimed regardless of the address select bit.
// - Input status one bits 5:4 show two palette colour bits, chosen externally.
// - Input status one bit 3 reads 1 while vertical sync is active.
// - Input status one bit 0 reads 1 during any retrace interval.
// - Feature control written at 3BA/3DA, read at 3CA.
// - Feature control bit 3 ORs retrace flag into vertical sync output.
// - Misc output bits 7 and 6 invert vertical and horizontal sync.
// - Misc output bit 5 selects upper or lower 64 KB page while odd_even_map_i is set.
// - Misc output bits 3:2 select the dot clock source.
// - Misc output bit 1 gates claiming of the A0000-BFFFF window.
// - Misc output written at 3C2, read at 3CC; status zero read at 3C2.
// - Sequencer data port accesses the register named by the stored index.
// - Sequencer index holds three bits; upper bits read zero.
// - Sequencer scratch bits 1:0 are plain storage with no effect.
// - Clocking mode bit 5 blanks video while syncs continue.
// - Shift registers load every 4th, 2nd or every character clock.
// - Clocking mode bit 3 halves the pixel clock and stretches timing.
// - Clocking mode bit 0 selects 8 or 9 dots per character.
// - Registers reachable in I/O and memory space at the same offset.
module dss_regs (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Host register port, I/O or memory window
	input wire logic io_cyc_i,
	input wire logic mem_cyc_i,
	input wire logic [15:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic claim_o,
	// Legacy frame buffer window decode from the host
	input wire logic fb_window_hit_i,
	output logic fb_claim_o,
	// Status from display timing and other register groups
	input wire logic vsync_raw_i,
	input wire logic hsync_raw_i,
	input wire logic retrace_flag_i,
	input wire logic vretrace_start_i,
	input wire logic sense_cmp_i,
	input wire logic [7:0] palette_bits_i,
	input wire logic [1:0] vertical_retrace_end_reg_i,
	input wire logic [1:0] colour_plane_enable_reg_i,
	input wire logic odd_even_map_i,
	// Display-side controls
	output logic vsync_o,
	output logic hsync_o,
	output logic blank_o,
	output logic page_lower_o,
	output dss_pkg::dss_clk_sel_t dot_clk_sel_o,
	output logic dot_div2_o,
	output logic pclk_en_o,
	output logic char_clk_o,
	output logic shift_load_o
);
	import dss_pkg::*;

	logic [7:0] misc_ff, nxt_misc;
	logic [7:0] feat_ff, nxt_feat;
	logic [2:0] index_ff, nxt_index;
	logic [7:0] scratch_ff, nxt_scratch;
	logic [7:0] clkmode_ff, nxt_clkmode;
	logic irq_pend_ff, nxt_irq_pend;
	logic [7:0] rdata_ff, nxt_rdata;
	logic vs_s, hs_s, rt_s, cmp_s, vst_s;
	logic [7:0] pal_s;
	logic pclk_ph_ff;
	logic [3:0] dot_cnt_ff, nxt_dot_cnt;
	logic [1:0] load_cnt_ff, nxt_load_cnt;
	logic char_ff, load_ff;
	logic vsync_ff, hsync_ff, blank_ff;

	wire any_cyc = io_cyc_i | mem_cyc_i;
	// Either range decodes; the select bit is kept but not yet honoured
	wire hit_stat1 = (addr_i == ADDR_STAT1_MONO) |
		(addr_i == ADDR_STAT1_COLR);
	wire hit_stat0 = addr_i == ADDR_STAT0;
	wire hit_index = addr_i == ADDR_SEQ_INDEX;
	wire hit_data = addr_i == ADDR_SEQ_DATA;
	wire hit_feat_rd = addr_i == ADDR_FEAT_RD;
	wire hit_misc_rd = addr_i == ADDR_MISC_RD;
	wire wr_en = any_cyc & wr_i;
	wire rd_en = any_cyc & rd_i;
	wire wr_misc = wr_en & hit_stat0;
	wire wr_feat = wr_en & hit_stat1;
	wire wr_index = wr_en & hit_index;
	wire wr_data = wr_en & hit_data;
	wire wr_scratch = wr_data & (index_ff == SEQ_IDX_SCRATCH);
	wire wr_clkmode = wr_data & (index_ff == SEQ_IDX_CLKMODE);
	wire rd_hit = hit_stat0 | hit_stat1 | hit_index | hit_data |
		hit_feat_rd | hit_misc_rd;
	wire wr_hit = hit_stat0 | hit_stat1 | hit_index | hit_data;
	assign claim_o = any_cyc & ((rd_i & rd_hit) | (wr_i & wr_hit));

	// Display timing levels arrive unrelated to the host clock
	dss_sync2 #(.WIDTH(1)) vs_sync_u (
		.mclk_i,
		.resetn_i,
		.async_i(vsync_raw_i),
		.sync_o(vs_s)
	);
	dss_sync2 #(.WIDTH(1)) hs_sync_u (
		.mclk_i,
		.resetn_i,
		.async_i(hsync_raw_i),
		.sync_o(hs_s)
	);
	dss_sync2 #(.WIDTH(1)) rt_sync_u (
		.mclk_i,
		.resetn_i,
		.async_i(retrace_flag_i),
		.sync_o(rt_s)
	);
	dss_sync2 #(.WIDTH(1)) cmp_sync_u (
		.mclk_i,
		.resetn_i,
		.async_i(sense_cmp_i),
		.sync_o(cmp_s)
	);
	dss_sync2 #(.WIDTH(1)) vst_sync_u (
		.mclk_i,
		.resetn_i,
		.async_i(vretrace_start_i),
		.sync_o(vst_s)
	);
	dss_sync2 #(.WIDTH(8)) pal_sync_u (
		.mclk_i,
		.resetn_i,
		.async_i(palette_bits_i),
		.sync_o(pal_s)
	);
	logic vst_d_ff;
	wire vst_rise = vst_s & ~vst_d_ff;
	wire irq_en = vertical_retrace_end_reg_i != 2'h0;
	wire clr_irq = ~irq_en;
	// A simultaneous disable wins over set; set needs the enable
	assign nxt_irq_pend = (irq_en & vst_rise) |
		(irq_pend_ff & ~clr_irq);

	wire [2:0] vfb_sel = {colour_plane_enable_reg_i, 1'b0};
	wire [1:0] vfb = {pal_s[vfb_sel + 3'h1],
		pal_s[vfb_sel]};
	wire [7:0] stat0_val = ({7'h00, irq_pend_ff} << ST0_IRQ_BIT) |
		({7'h00, cmp_s} << ST0_SENSE_BIT);
	wire [7:0] stat1_val = ({6'h00, vfb} << ST1_VFB_LO) |
		({7'h00, vs_s} << ST1_VRT_BIT) |
		({7'h00, rt_s} << ST1_RETRACE_BIT);
	wire [7:0] seq_val = (index_ff == SEQ_IDX_SCRATCH) ? scratch_ff :
		(index_ff == SEQ_IDX_CLKMODE) ? clkmode_ff : RST_BYTE;

	always_comb begin
		nxt_rdata = rdata_ff;
		if (rd_en) begin
			if (hit_stat0)
				nxt_rdata = stat0_val;
			else if (hit_stat1)
				nxt_rdata = stat1_val;
			else if (hit_index)
				nxt_rdata = {5'h00, index_ff};
			else if (hit_data)
				nxt_rdata = seq_val;
			else if (hit_feat_rd)
				nxt_rdata = feat_ff;
			else if (hit_misc_rd)
				nxt_rdata = misc_ff;
			else
				nxt_rdata = RST_BYTE;
		end
	end

	assign nxt_misc = wr_misc ? (wdata_i & MASK_MISC) : misc_ff;
	assign nxt_feat = wr_feat ? (wdata_i & MASK_FEAT) : feat_ff;
	assign nxt_index = wr_index ? (wdata_i[2:0] & MASK_INDEX) : index_ff;
	assign nxt_scratch = wr_scratch ? (wdata_i & MASK_SCRATCH) :
		scratch_ff;
	assign nxt_clkmode = wr_clkmode ? (wdata_i & MASK_CLKMODE) :
		clkmode_ff;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			misc_ff <= RST_BYTE;
		end else begin
			misc_ff <= nxt_misc;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			feat_ff <= RST_BYTE;
		end else begin
			feat_ff <= nxt_feat;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			index_ff <= 3'h0;
		end else begin
			index_ff <= nxt_index;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scratch_ff <= RST_BYTE;
		end else begin
			scratch_ff <= nxt_scratch;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			clkmode_ff <= RST_BYTE;
		end else begin
			clkmode_ff <= nxt_clkmode;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_ff <= RST_BYTE;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end
	assign rdata_o = rdata_ff;

	// Edge detect on the synchronised level only
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			vst_d_ff <= 1'b0;
		end else begin
			vst_d_ff <= vst_s;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_pend_ff <= 1'b0;
		end else begin
			irq_pend_ff <= nxt_irq_pend;
		end
	end

	// Memory window claim gated by access enable
	assign fb_claim_o = fb_window_hit_i & misc_ff[MISC_MEMEN_BIT];
	assign page_lower_o = odd_even_map_i & misc_ff[MISC_PAGE_BIT];
	assign dot_clk_sel_o = misc_ff[MISC_CLK_LO + 1] ? DSS_CLK_PROG :
		dss_clk_sel_t'({1'b0, misc_ff[MISC_CLK_LO]});
	assign dot_div2_o = clkmode_ff[CM_DIV_BIT];

	// Pixel enable halves the dot rate when divide is on
	wire pix_tick = ~clkmode_ff[CM_DIV_BIT] | pclk_ph_ff;
	wire [3:0] char_len = clkmode_ff[CM_DOT8_BIT] ? CHAR_LEN_8 :
		CHAR_LEN_9;
	wire char_end = pix_tick & (dot_cnt_ff >= char_len);
	assign nxt_dot_cnt = !pix_tick ? dot_cnt_ff :
		char_end ? 4'h0 : dot_cnt_ff + 4'h1;
	wire [1:0] load_per = clkmode_ff[CM_SH4_BIT] ? LOAD_EVERY_4 :
		clkmode_ff[CM_SH2_BIT] ? LOAD_EVERY_2 : LOAD_EVERY_1;
	wire load_end = char_end & (load_cnt_ff >= load_per);
	assign nxt_load_cnt = !char_end ? load_cnt_ff :
		load_end ? 2'h0 : load_cnt_ff + 2'h1;

	// Sync combine and polarity; blanking leaves syncs running
	wire vs_comb = feat_ff[FC_VSYNC_OR_BIT] ? (vs_s | rt_s) :
		vs_s;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pclk_ph_ff <= 1'b0;
		end else begin
			pclk_ph_ff <= ~pclk_ph_ff;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dot_cnt_ff <= 4'h0;
		end else begin
			dot_cnt_ff <= nxt_dot_cnt;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			load_cnt_ff <= 2'h0;
		end else begin
			load_cnt_ff <= nxt_load_cnt;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			char_ff <= 1'b0;
		end else begin
			char_ff <= char_end;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			load_ff <= 1'b0;
		end else begin
			load_ff <= load_end & ~clkmode_ff[CM_OFF_BIT];
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			vsync_ff <= 1'b0;
		end else begin
			vsync_ff <= vs_comb ^ misc_ff[MISC_VPOL_BIT];
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hsync_ff <= 1'b0;
		end else begin
			hsync_ff <= hs_s ^ misc_ff[MISC_HPOL_BIT];
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			blank_ff <= 1'b0;
		end else begin
			blank_ff <= clkmode_ff[CM_OFF_BIT] | rt_s;
		end
	end
	assign pclk_en_o = pix_tick;
	assign char_clk_o = char_ff;
	assign shift_load_o = load_ff;
	assign vsync_o = vsync_ff;
	assign hsync_o = hsync_ff;
	assign blank_o = blank_ff;
endmodule : dss_regs

// Two-stage synchroniser for levels from the display timing domain
module dss_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Asynchronous level in, synchronised level out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// Only the second stage is read, keeping metastability contained
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end
	assign sync_o = sync_ff;
endmodule : dss_sync2
`default_nettype wire

// ===== dss_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dss_regs_chk (
	// Clock, reset and host port
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic io_cyc_i,
	input wire logic mem_cyc_i,
	input wire logic [15:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic claim_o,
	// Display side
	input wire logic fb_window_hit_i,
	input wire logic fb_claim_o,
	input wire logic hsync_raw_i,
	input wire logic hsync_o,
	input wire logic blank_o,
	input wire logic pclk_en_o,
	input wire dss_pkg::dss_clk_sel_t dot_clk_sel_o
);
	import dss_pkg::*;
	logic [7:0] misc_sh;
	logic [7:0] cm_sh;
	logic [2:0] idx_sh;
	wire logic cyc = io_cyc_i | mem_cyc_i;
	// Shadow copies of the misc, index and clocking mode fields, masked as the design keeps them
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			misc_sh <= RST_BYTE;
			cm_sh <= RST_BYTE;
			idx_sh <= 3'h0;
		end else if (cyc && wr_i) begin
			if (addr_i == ADDR_MISC_WR) misc_sh <= wdata_i & MASK_MISC;
			if (addr_i == ADDR_SEQ_INDEX) idx_sh <= wdata_i[2:0];
			if (addr_i == ADDR_SEQ_DATA && idx_sh == SEQ_IDX_CLKMODE)
				cm_sh <= wdata_i & MASK_CLKMODE;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	property p_misc_rd;
		cyc && rd_i && addr_i == ADDR_MISC_RD |=> rdata_o == $past(misc_sh);
	endproperty
	a_misc_rd: assert property (p_misc_rd) else $error("misc readback");
	property p_idx_rd;
		cyc && rd_i && addr_i == ADDR_SEQ_INDEX |=> rdata_o == {5'h00, $past(idx_sh)};
	endproperty
	a_idx_rd: assert property (p_idx_rd) else $error("index readback");
	property p_claim_both;
		cyc && (rd_i || wr_i) && (addr_i == ADDR_STAT1_MONO ||
			addr_i == ADDR_STAT1_COLR) |-> claim_o;
	endproperty
	a_claim_both: assert property (p_claim_both) else $error("range unclaimed");
	property p_fb;
		fb_claim_o == (fb_window_hit_i && misc_sh[MISC_MEMEN_BIT]);
	endproperty
	a_fb: assert property (p_fb) else $error("window claim wrong");
	property p_clk;
		dot_clk_sel_o == (misc_sh[3] ? 2'h2 : misc_sh[3:2]);
	endproperty
	a_clk: assert property (p_clk) else $error("dot clock select");
	property p_hpol;
		hsync_o == ($past(hsync_raw_i, 3) ^ $past(misc_sh[MISC_HPOL_BIT]));
	endproperty
	a_hpol: assert property (p_hpol) else $error("hsync polarity");
	property p_blank;
		$past(cm_sh[CM_OFF_BIT]) |-> blank_o;
	endproperty
	a_blank: assert property (p_blank) else $error("screen not blanked");
	property p_pclk_on;
		!cm_sh[CM_DIV_BIT] |-> pclk_en_o;
	endproperty
	a_pclk_on: assert property (p_pclk_on) else $error("pixel tick gap");
	property p_pclk_div;
		cm_sh[CM_DIV_BIT] && pclk_en_o |=> !pclk_en_o || !cm_sh[CM_DIV_BIT];
	endproperty
	a_pclk_div: assert property (p_pclk_div) else $error("pixel not halved");
endmodule : dss_regs_chk
bind dss_regs dss_regs_chk chk_u (.mclk_i, .resetn_i, .io_cyc_i, .mem_cyc_i,
	.addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o, .claim_o, .fb_window_hit_i,
	.fb_claim_o, .hsync_raw_i, .hsync_o, .blank_o, .pclk_en_o, .dot_clk_sel_o);
`default_nettype wire

// ===== dss_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dss_monitor #(parameter bit COLOUR = 1'b1) (
	// Sync in, sense out
	input wire logic vsync_i,
	output logic sense_o,
	output var int frames_o
);
	// Sense load fixed: a colour tube is attached
	assign sense_o = COLOUR;
	initial frames_o = 0;
	always @(posedge vsync_i) frames_o++;
endmodule : dss_monitor
`default_nettype wire

// ===== dss_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dss_pkg::*;
	logic mclk_i, resetn_i, io_cyc_i, mem_cyc_i, wr_i, rd_i, claim_o;
	logic fb_window_hit_i, vsync_raw_i, hsync_raw_i, retrace_flag_i;
	logic vretrace_start_i, sense_cmp_i, odd_even_map_i, fb_claim_o;
	logic [15:0] addr_i;
	logic [7:0] wdata_i, rdata_o, palette_bits_i;
	logic [1:0] vertical_retrace_end_reg_i, colour_plane_enable_reg_i;
	logic vsync_o, hsync_o, blank_o, page_lower_o, dot_div2_o, pclk_en_o;
	logic char_clk_o, shift_load_o;
	dss_clk_sel_t dot_clk_sel_o;
	int err_total, checked, frames, f0, chars, loads;
	localparam int PER[5] = '{9, 8, 9, 9, 18};
	localparam int LDIV[5] = '{1, 1, 2, 4, 1};
	localparam logic [7:0] CMV[5] = '{8'h00, 8'h01, 8'h04, 8'h10, 8'h08};
	dss_regs dut_u (.mclk_i, .resetn_i, .io_cyc_i, .mem_cyc_i, .addr_i, .wr_i,
		.rd_i, .wdata_i, .rdata_o, .claim_o, .fb_window_hit_i, .fb_claim_o,
		.vsync_raw_i, .hsync_raw_i, .retrace_flag_i, .vretrace_start_i,
		.sense_cmp_i, .palette_bits_i, .vertical_retrace_end_reg_i,
		.colour_plane_enable_reg_i, .odd_even_map_i, .vsync_o, .hsync_o,
		.blank_o, .page_lower_o, .dot_clk_sel_o, .dot_div2_o, .pclk_en_o,
		.char_clk_o, .shift_load_o);
	dss_monitor mon_u (.vsync_i(vsync_o), .sense_o(sense_cmp_i), .frames_o(frames));
	task automatic check(input string n, input logic [7:0] s, e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic test_done();
		if (err_total == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : test_done
	task automatic drv(input bit sp, w, r, input logic [15:0] a, input logic [7:0] d);
		io_cyc_i <= !sp && (w || r);
		mem_cyc_i <= sp && (w || r);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= d;
	endtask : drv
	task automatic wr(input bit sp, input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i) drv(sp, 1, 0, a, d);
		@(posedge mclk_i) drv(0, 0, 0, a, d);
		#1;
	endtask : wr
	task automatic rd(input bit sp, input logic [15:0] a, input logic [7:0] e,
		input string n);
		@(posedge mclk_i) drv(sp, 0, 1, a, 8'h00);
		@(posedge mclk_i) drv(0, 0, 0, a, 8'h00);
		@(posedge mclk_i) #1 check(n, rdata_o, e);
	endtask : rd
	initial begin
		mclk_i = 0;
		forever #20 mclk_i = ~mclk_i;
	end
	// Whole run is about 4000 cycles
	initial begin
		#400000 err_total++;
		test_done();
	end
	initial begin
		err_total = 0;
		checked = 0;
		resetn_i = 0;
		drv(0, 0, 0, 16'h0000, 8'h00);
		{fb_window_hit_i, vsync_raw_i, hsync_raw_i, retrace_flag_i} = 4'h0;
		{vretrace_start_i, odd_even_map_i, palette_bits_i} = 10'h000;
		{vertical_retrace_end_reg_i, colour_plane_enable_reg_i} = 4'h0;
		repeat (8) @(posedge mclk_i);
		resetn_i <= 1;
		repeat (4) @(posedge mclk_i);
		rd(0, ADDR_STAT0, 8'h10, "status0");
		rd(1, ADDR_FEAT_RD, 8'h00, "feature");
		for (int i = 0; i < 4; i++) begin
			wr(i[0], ADDR_MISC_WR, {4'hF, i[1:0], 2'h3});
			rd(i[1], ADDR_MISC_RD, {4'hE, i[1:0], 2'h3}, "misc");
			check("clksel", {6'h00, dot_clk_sel_o}, i[1] ? 8'h02 : 8'(i));
		end
		fb_window_hit_i <= 1;
		odd_even_map_i <= 1;
		@(posedge mclk_i) #1 check("fbclaim", {7'h00, fb_claim_o}, 8'h01);
		wr(0, ADDR_MISC_WR, 8'h20);
		check("fbclaim", {7'h00, fb_claim_o}, 8'h00);
		check("page", {7'h00, page_lower_o}, 8'h01);
		wr(0, ADDR_STAT1_COLR, 8'hFF);
		rd(0, ADDR_FEAT_RD, 8'h08, "feature");
		retrace_flag_i <= 1;
		repeat (5) @(posedge mclk_i);
		#1 check("vsync", {7'h00, vsync_o}, 8'h01);
		wr(0, ADDR_STAT1_MONO, 8'h00);
		repeat (5) @(posedge mclk_i);
		#1 check("vsync", {7'h00, vsync_o}, 8'h00);
		wr(0, ADDR_MISC_WR, 8'hC0);
		repeat (2) @(posedge mclk_i);
		#1 check("syncpol", {6'h00, hsync_o, vsync_o}, 8'h03);
		wr(0, ADDR_MISC_WR, 8'h00);
		vsync_raw_i <= 1;
		palette_bits_i <= 8'h20;
		colour_plane_enable_reg_i <= 2'h2;
		vertical_retrace_end_reg_i <= 2'h1;
		vretrace_start_i <= 1;
		repeat (4) @(posedge mclk_i);
		rd(0, ADDR_STAT1_COLR, 8'h29, "status1");
		rd(0, ADDR_STAT0, 8'h90, "irq");
		{vsync_raw_i, retrace_flag_i, vretrace_start_i} <= 3'h0;
		vertical_retrace_end_reg_i <= 2'h0;
		repeat (4) @(posedge mclk_i);
		rd(0, ADDR_STAT1_MONO, 8'h20, "status1");
		rd(0, ADDR_STAT0, 8'h10, "irq");
		wr(0, ADDR_SEQ_INDEX, 8'hF8);
		rd(0, ADDR_SEQ_INDEX, 8'h00, "index");
		wr(0, ADDR_SEQ_DATA, 8'hFF);
		rd(0, ADDR_SEQ_DATA, 8'h03, "scratch");
		wr(1, ADDR_SEQ_INDEX, 8'h05);
		wr(1, ADDR_SEQ_DATA, 8'hFF);
		rd(1, ADDR_SEQ_DATA, 8'h00, "index5");
		wr(0, ADDR_SEQ_INDEX, 8'h01);
		wr(0, ADDR_SEQ_DATA, 8'hFF);
		rd(0, ADDR_SEQ_DATA, 8'h3D, "clkmode");
		check("blank", {7'h00, blank_o}, 8'h01);
		f0 = frames;
		repeat (4) @(posedge mclk_i) {vsync_raw_i, hsync_raw_i} <=
			~{vsync_raw_i, hsync_raw_i};
		repeat (3) @(posedge mclk_i);
		check("frames", 8'(frames - f0), 8'h02);
		for (int k = 0; k < 5; k++) begin
			wr(0, ADDR_SEQ_DATA, CMV[k]);
			chars = 0;
			loads = 0;
			repeat (720) @(posedge mclk_i) #1 {chars, loads} =
				{chars + char_clk_o, loads + shift_load_o};
			check("chars", {7'h00, (chars + 1 - 720 / PER[k]) inside {[0:2]}}, 8'h01);
			check("loads", {7'h00, (loads + 1 - chars / LDIV[k]) inside {[0:2]}}, 8'h01);
			check("div2", {4'h0, dot_div2_o, 3'h0}, CMV[k] & 8'h08);
		end
		test_done();
	end
endmodule : testbench
`default_nettype wire
